// >>> asrp_params.svh
// Constants of the serial result port: field positions, widths and timing.
`ifndef ASRP_PARAMS_SVH
`define ASRP_PARAMS_SVH

`define ASRP_WORD_BITS      16
`define ASRP_RESULT_BITS    12
`define ASRP_TAG_BITS       4
`define ASRP_CMD_BITS       16
`define ASRP_FIFO_DEPTH     8
`define ASRP_CLK_HZ         25000000
`define ASRP_SCLK_MAX_HZ    16000000
`define ASRP_RES_12         2'h0
`define ASRP_RES_10         2'h1
`define ASRP_RES_8          2'h2
`define ASRP_LSB_MASK_10    12'hFFC
`define ASRP_LSB_MASK_8     12'hFF0
`define ASRP_CMD_TAG_LSB    11
`define ASRP_CMD_CHAN_LSB   7

`endif

// >>> asrp_pkg.sv
// Types of the serial result port: result word, command and link state.
`default_nettype none

package asrp_pkg;

	typedef struct packed
	{
		logic [3:0]  tag;
		logic [11:0] value;
	} asrp_result_t;

	typedef struct packed
	{
		logic [15:0] word;
		logic        valid;
	} asrp_command_t;

	typedef enum logic [2:0]
	{
		ASRP_IDLE  = 3'h1,
		ASRP_SHIFT = 3'h2,
		ASRP_DONE  = 3'h4
	} asrp_state_t;

endpackage

`default_nettype wire

// >>> asrp_fifo.sv
// Result buffer of flip-flops with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module asrp_fifo
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
)
(
	// Clock and reset.
	input  wire logic             i_clock,
	input  wire logic             i_reset_n,
	// Fill side.
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Drain side.
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);

	localparam int AW = $clog2(DEPTH);

	// ==========================================================
	// State.
	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               rd;
		logic [AW-1:0]               wr;
		logic [AW:0]                 count;
		logic                        ready;
	} asrp_fifo_state_t;

	asrp_fifo_state_t s_q;
	asrp_fifo_state_t s_d;
	logic             push;
	logic             pop;

	// Ready is kept in a flop so that the fill side sees a clean register, at the cost of one bit of state.
	assign o_in_ready  = s_q.ready;
	assign o_out_valid = (s_q.count != '0);
	assign o_out_data  = s_q.mem[s_q.rd];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_comb
	begin
		s_d = s_q;
		if (push)
		begin
			s_d.mem[s_q.wr] = i_in_data;
			s_d.wr          = s_q.wr + 1'b1;
		end
		if (pop)
			s_d.rd = s_q.rd + 1'b1;
		if (push && !pop)
			s_d.count = s_q.count + 1'b1;
		else if (pop && !push)
			s_d.count = s_q.count - 1'b1;
		s_d.ready = (s_d.count != DEPTH[AW:0]);
	end

	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			s_q       <= '0;
			s_q.ready <= 1'b1;
		end
		else
			s_q <= s_d;
	end

endmodule

`default_nettype wire

// >>> asrp_port.sv
// Serial result port of a multichannel converter, SPI mode 3 slave.
`timescale 1ns/1ps
`default_nettype none
`include "asrp_params.svh"

module asrp_port
(
	// Clock and reset.
	input  wire logic        i_clock,
	input  wire logic        i_reset_n,
	// Serial link pins.
	input  wire logic        i_sclk,
	input  wire logic        i_cs_n,
	input  wire logic        i_din,
	output logic             o_dout,
	output logic             o_dout_oe,
	// Conversion control pins.
	input  wire logic        i_convert_request_n,
	output logic             o_eoc_n,
	// Converter side.
	input  wire logic        i_channel_tag_enable,
	input  wire logic        i_internal_clock_mode,
	input  wire logic [1:0]  i_resolution,
	output logic             o_sample,
	output logic             o_convert_start,
	output logic [3:0]       o_channel,
	input  wire logic        i_result_valid,
	input  wire logic [15:0] i_result,
	output logic             o_result_ready,
	output logic [15:0]      o_command,
	output logic             o_command_valid
);

	// ==========================================================
	// State.
	typedef struct packed
	{
		logic [1:0]             sclk_sync;
		logic [1:0]             cs_sync;
		logic [1:0]             din_sync;
		logic [1:0]             cnv_sync;
		logic                   sclk_prev;
		logic                   cs_prev;
		logic                   cnv_prev;
		asrp_pkg::asrp_state_t  state;
		logic [4:0]             bit_count;
		logic [15:0]            shift_out;
		logic [15:0]            shift_in;
		logic [15:0]            pending;
		logic                   dout;
		logic                   dout_oe;
		logic                   eoc_n;
		logic                   sample;
		logic                   convert_start;
		logic [3:0]             channel;
		logic                   pop;
		asrp_pkg::asrp_command_t command;
	} asrp_port_state_t;

	asrp_port_state_t s_q;
	asrp_port_state_t s_d;

	logic                   buf_valid;
	logic [15:0]            buf_data;
	asrp_pkg::asrp_result_t head;
	logic [11:0]            value;
	logic [15:0]            word;

	// The buffer decouples the converter from a slow master; when it fills, the converter is stalled.
	asrp_fifo #(.WIDTH(`ASRP_WORD_BITS), .DEPTH(`ASRP_FIFO_DEPTH)) u_fifo
	(
		.i_clock     (i_clock),
		.i_reset_n   (i_reset_n),
		.i_in_valid  (i_result_valid),
		.i_in_data   (i_result),
		.o_in_ready  (o_result_ready),
		.o_out_valid (buf_valid),
		.o_out_data  (buf_data),
		.i_out_ready (s_q.pop)
	);

	// ==========================================================
	// Word formatting.
	always_comb
	begin
		head  = asrp_pkg::asrp_result_t'(buf_data);
		value = head.value;
		if (i_resolution == `ASRP_RES_10)
			value = value & `ASRP_LSB_MASK_10;
		else if (i_resolution == `ASRP_RES_8)
			value = value & `ASRP_LSB_MASK_8;
		if (!buf_valid)
			word = 16'h0000;
		else if (i_channel_tag_enable)
			word = {head.tag, value};
		else
			word = {1'b0, value, 3'h0};
	end

	// ==========================================================
	// Link sequencing. Pins pass two flip-flops, so edges are seen a few cycles late;
	// this limits the serial clock to well below the system clock.
	always_comb
	begin
		s_d               = s_q;
		s_d.sclk_sync     = {s_q.sclk_sync[0], i_sclk};
		s_d.cs_sync       = {s_q.cs_sync[0], i_cs_n};
		s_d.din_sync      = {s_q.din_sync[0], i_din};
		s_d.cnv_sync      = {s_q.cnv_sync[0], i_convert_request_n};
		s_d.sclk_prev     = s_q.sclk_sync[1];
		s_d.cs_prev       = s_q.cs_sync[1];
		s_d.cnv_prev      = s_q.cnv_sync[1];
		s_d.sample        = 1'b0;
		s_d.convert_start = 1'b0;
		s_d.pop           = 1'b0;
		s_d.command.valid = 1'b0;

		if (s_q.cnv_prev && !s_q.cnv_sync[1] && s_q.cs_sync[1])
		begin
			s_d.convert_start = 1'b1;
			s_d.eoc_n         = 1'b1;
		end
		if (i_internal_clock_mode && buf_valid && s_q.cs_sync[1])
			s_d.eoc_n = 1'b0;

		case (s_q.state)
			asrp_pkg::ASRP_IDLE:
			begin
				s_d.dout_oe = 1'b0;
				if (s_q.cs_prev && !s_q.cs_sync[1])
				begin
					s_d.sample    = 1'b1;
					s_d.channel   = s_q.pending[`ASRP_CMD_CHAN_LSB +: 4];
					s_d.bit_count = 5'h0;
					s_d.shift_out = {word[14:0], 1'b0};
					s_d.dout      = word[15];
					s_d.dout_oe   = 1'b1;
					s_d.pop       = buf_valid;
					s_d.eoc_n     = 1'b1;
					s_d.state     = asrp_pkg::ASRP_SHIFT;
				end
			end
			asrp_pkg::ASRP_SHIFT, asrp_pkg::ASRP_DONE:
			begin
				if (s_q.cs_sync[1])
				begin
					s_d.dout_oe = 1'b0;
					s_d.state   = asrp_pkg::ASRP_IDLE;
				end
				else if (!s_q.sclk_prev && s_q.sclk_sync[1] && s_q.state == asrp_pkg::ASRP_SHIFT)
				begin
					s_d.shift_in  = {s_q.shift_in[14:0], s_q.din_sync[1]};
					s_d.bit_count = s_q.bit_count + 5'h1;
					if (s_q.bit_count == 5'(`ASRP_CMD_BITS - 1))
					begin
						s_d.command.word  = {s_q.shift_in[14:0], s_q.din_sync[1]};
						s_d.command.valid = 1'b1;
						s_d.pending       = {s_q.shift_in[14:0], s_q.din_sync[1]};
						s_d.state         = asrp_pkg::ASRP_DONE;
					end
				end
				else if (s_q.sclk_prev && !s_q.sclk_sync[1] && s_q.state == asrp_pkg::ASRP_SHIFT)
				begin
					s_d.dout      = s_q.shift_out[15];
					s_d.shift_out = {s_q.shift_out[14:0], 1'b0};
				end
			end
			default:
				s_d.state = asrp_pkg::ASRP_IDLE;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			s_q           <= '0;
			s_q.sclk_sync <= 2'h3;
			s_q.cs_sync   <= 2'h3;
			s_q.cnv_sync  <= 2'h3;
			s_q.sclk_prev <= 1'b1;
			s_q.cs_prev   <= 1'b1;
			s_q.cnv_prev  <= 1'b1;
			s_q.eoc_n     <= 1'b1;
			s_q.state     <= asrp_pkg::ASRP_IDLE;
		end
		else
			s_q <= s_d;
	end

	assign o_dout          = s_q.dout;
	assign o_dout_oe       = s_q.dout_oe;
	assign o_eoc_n         = s_q.eoc_n;
	assign o_sample        = s_q.sample;
	assign o_convert_start = s_q.convert_start;
	assign o_channel       = s_q.channel;
	assign o_command       = s_q.command.word;
	assign o_command_valid = s_q.command.valid;

endmodule

`default_nettype wire

// >>> asrp_port_monitor.sv
// Pin checker of the serial result port.
`timescale 1ns/1ps
`default_nettype none
module asrp_port_monitor
(
	// Clock, reset and link inputs.
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_convert_request_n,
	input wire logic i_internal_clock_mode,
	// Watched outputs.
	input wire logic o_dout,
	input wire logic o_dout_oe,
	input wire logic o_eoc_n,
	input wire logic o_sample,
	input wire logic o_convert_start,
	input wire logic o_command_valid
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	property p_off; i_cs_n[*6] |-> !o_dout_oe; endproperty
	a_off: assert property (p_off) else $error("oe high");
	property p_on; (!i_cs_n)[*7] |-> o_dout_oe; endproperty
	a_on: assert property (p_on) else $error("oe low");
	property p_frm; $fell(i_cs_n) |-> ##[1:6] o_sample; endproperty
	a_frm: assert property (p_frm) else $error("no sample");
	property p_hold; $changed(o_dout) && !o_sample |-> !$past(i_sclk, 3); endproperty
	a_hold: assert property (p_hold) else $error("dout moved");
	property p_cmd; o_command_valid |-> !$past(i_cs_n, 4); endproperty
	a_cmd: assert property (p_cmd) else $error("stray command");
	property p_one; o_command_valid |=> !o_command_valid; endproperty
	a_one: assert property (p_one) else $error("long command");
	property p_eoc; $fell(o_eoc_n) |-> $past(i_internal_clock_mode); endproperty
	a_eoc: assert property (p_eoc) else $error("eoc mode");
	property p_cnv; $fell(i_convert_request_n) && i_cs_n |-> ##[1:6] o_convert_start; endproperty
	a_cnv: assert property (p_cnv) else $error("no start");
endmodule
bind asrp_port asrp_port_monitor asrp_port_monitor_i
(
	.i_clock(i_clock), .i_reset_n(i_reset_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
	.i_convert_request_n(i_convert_request_n), .i_internal_clock_mode(i_internal_clock_mode),
	.o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_eoc_n(o_eoc_n), .o_sample(o_sample),
	.o_convert_start(o_convert_start), .o_command_valid(o_command_valid)
);
`default_nettype wire

// >>> asrp_master.sv
// Mode three serial master model that reads result words.
`timescale 1ns/1ps
`default_nettype none
module asrp_master
(
	// Pacing clock.
	input  wire logic i_clock,
	// Serial pins.
	input  wire logic i_dout,
	input  wire logic i_dout_oe,
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_din
);
	logic pin;
	// A released line shows the inverse of its last bit, so stale data cannot pass.
	assign pin = i_dout_oe ? i_dout : ~i_dout;
	initial
	begin
		o_sclk = 1'h1;
		o_cs_n = 1'h1;
		o_din = 1'h0;
	end
	// Half periods of four clocks give a 320 ns period, well below the rate ceiling.
	task automatic frame(input logic [15:0] cmd, input int n, output logic [15:0] rx);
		repeat (8) @(posedge i_clock);
		o_cs_n <= 1'h0;
		repeat (8) @(posedge i_clock);
		for (int k = 0; k < n; k++)
		begin
			rx = {rx[14:0], pin};
			o_sclk <= 1'h0;
			o_din <= cmd[15-k];
			repeat (4) @(posedge i_clock);
			o_sclk <= 1'h1;
			repeat (4) @(posedge i_clock);
		end
		o_cs_n <= 1'h1;
	endtask
endmodule
`default_nettype wire

// >>> asrp_port_test.sv
// Self-checking bench of the serial result port.
`timescale 1ns/1ps
`default_nettype none
`include "asrp_params.svh"
module asrp_port_test;
	logic        clk, rst_n, sclk, cs_n, din, dout, oe, eoc_n, ready, conv_n, tag, imode, rv;
	logic [1:0]  res;
	logic [3:0]  chan;
	logic [15:0] rd, rx, cmd, prev, r, ocmd;
	logic [15:0] q[$];
	int          n_fail, checked, seed, cyc, i;
	asrp_port asrp_port_i
	(
		.i_clock(clk), .i_reset_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
		.o_dout(dout), .o_dout_oe(oe), .i_convert_request_n(conv_n), .o_eoc_n(eoc_n),
		.i_channel_tag_enable(tag), .i_internal_clock_mode(imode), .i_resolution(res),
		.o_sample(), .o_convert_start(), .o_channel(chan), .i_result_valid(rv), .i_result(rd),
		.o_result_ready(ready), .o_command(ocmd), .o_command_valid()
	);
	asrp_master asrp_master_i
	(
		.i_clock(clk), .i_dout(dout), .i_dout_oe(oe), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din)
	);
	initial
	begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	task automatic end_sim();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic logic [15:0] fmt(input logic [15:0] w, input logic t, input logic [1:0] rs);
		logic [11:0] v;
		v = w[11:0];
		if (rs == `ASRP_RES_10)
			v = v & `ASRP_LSB_MASK_10;
		if (rs == `ASRP_RES_8)
			v = v & `ASRP_LSB_MASK_8;
		return t ? {w[15:12], v} : {1'h0, v, 3'h0};
	endfunction
	task automatic push(input logic [15:0] w);
		rv <= 1'h1;
		rd <= w;
		do
			@(posedge clk);
		while (ready !== 1'h1);
		rv <= 1'h0;
		@(posedge clk);
	endtask
	task automatic run(input int n);
		cmd = $random(seed);
		asrp_master_i.frame(cmd, n, rx);
		repeat (8) @(posedge clk);
		if (n == 16)
		begin
			chk("command", ocmd, cmd);
			chk("channel", {12'h0, chan}, {12'h0, prev[`ASRP_CMD_CHAN_LSB +: 4]});
			prev = cmd;
		end
	endtask
	initial
	begin
		seed = 91155;
		rst_n = 1'h0;
		conv_n = 1'h1;
		tag = 1'h1;
		imode = 1'h0;
		res = 2'h0;
		rv = 1'h0;
		rd = 16'h0000;
		prev = 16'h0000;
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		run(16);
		chk("empty", rx, 16'h0000);
		for (i = 0; i < 6; i++)
		begin
			tag <= i[0];
			res <= i[2:1];
			r = $random(seed);
			push(r);
			run(16);
			chk("word", rx, fmt(r, i[0], i[2:1]));
		end
		tag <= 1'h1;
		res <= 2'h0;
		repeat (8)
		begin
			r = $random(seed);
			q.push_back(r);
			push(r);
		end
		chk("full", {15'h0, ready}, 16'h0000);
		repeat (9)
		begin
			run(16);
			chk("drain", rx, q.size() ? fmt(q.pop_front(), 1'h1, 2'h0) : 16'h0000);
		end
		r = $random(seed);
		push(r);
		push(~r);
		run(8);
		run(16);
		chk("restart", rx, fmt(~r, 1'h1, 2'h0));
		imode <= 1'h1;
		push(r);
		repeat (4) @(posedge clk);
		chk("eoc", {15'h0, eoc_n}, 16'h0000);
		conv_n <= 1'h0;
		repeat (3) @(posedge clk);
		conv_n <= 1'h1;
		run(16);
		chk("eoc", {15'h0, eoc_n}, 16'h0001);
		end_sim();
	end
endmodule
`default_nettype wire
